// >>> hw/bcs_top.sv
// Battery charge sequencer: phase control, timers and Wishbone registers.
// Assumes comparator and strap inputs synchronous to clk, classic Wishbone master.
//
// Chosen here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module bcs_top
   import bcs_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = TICK_CYC, // Cycles per ms tick
   parameter int unsigned SAFE_MS = T_SAFE_MS // Safety timer length in ms
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Classic Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Analog front end
   input wire bcs_ana_t ana_i,
   input wire bcs_strap_t precharge_threshold_strap,
   input wire bcs_strap_t term_strap,
   // Power stage control
   output bcs_ctl_t ctl_o,
   output logic timeout_fault,
   output logic charge_done
);
   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   // Last count of each timer; a phase ends on the tick after it
   localparam logic [CNT_W-1:0] TICK_LAST = CNT_W'(TICK_CYCLES - 1);
   localparam logic [CNT_W-1:0] SAFE_LAST = CNT_W'(SAFE_MS - 1);
   localparam logic [CNT_W-1:0] VALID_LAST = CNT_W'(T_VALID_MS - 1);
   localparam logic [CNT_W-1:0] TRK_ON_LAST = CNT_W'(T_TRK_ON_MS - 1);
   localparam logic [CNT_W-1:0] TRK_OFF_LAST = CNT_W'(T_TRK_OFF_MS - 1);
   localparam logic [CNT_W-1:0] DGL_LAST = CNT_W'(T_TERM_DGL_MS - 1);

   bcs_state_t state_q, state_d; // Sequencer state
   logic [CNT_W-1:0] div_q; // Tick divider
   logic tick_q; // One-cycle ms tick
   logic [CNT_W-1:0] ph_q; // Phase timer in ms
   logic [CNT_W-1:0] safe_q; // Safety timer in ms
   logic safe_exp; // Safety timer at its end
   logic [2:0] ctrl_q; // Control register
   bcs_strap_t pstrap_q, tstrap_q; // Straps latched for the cycle
   logic tout_q, done_q, float_q; // Status flags
   logic vin_valid; // Input qualified
   logic off_req; // Charging disabled from outside
   logic charging; // State draws charge current
   logic start; // Begin a new charge cycle
   logic wb_req; // Bus request not yet answered
   bcs_state_t entry; // First charging state of a cycle
   logic ph_done; // Phase timer at its limit

   // ----------------------------------------
   // Input qualification and entry state
   // ----------------------------------------
   // Input valid needs lockout and headroom both met
   assign vin_valid = ana_i.vin_uvlo_ok & ana_i.vin_hdrm_ok;
   // Sense node pulled low or controller stop turns the charger off
   // A stop also restarts qualification and the safety timer
   assign off_req = ana_i.input_voltage_sense_below_0v2 | ~ctrl_q[CTL_EN];
   assign charging = (state_q == S_TRK_ON) | (state_q == S_PRE) |
                     (state_q == S_CC) | (state_q == S_CV);

   // Pick the first phase from the live strap and battery level
   // Trickle wins: a deeply drained pack gets burst and pause
   // before any steady current
   always_comb begin
      if (ana_i.batt_below_trickle) begin
         entry = S_TRK_ON;
      end else if (precharge_threshold_strap == STRAP_VCC) begin
         entry = S_CC;
      end else if (ana_i.batt_above_pre) begin
         entry = S_CC;
      end else begin
         entry = S_PRE;
      end
   end

   // ----------------------------------------
   // Millisecond tick
   // ----------------------------------------
   // Divider gives a one-cycle enable every ms
   // Phases count ticks, so each may run up to one tick short,
   // depending on where the divider stands at entry
   always_ff @(posedge clk) begin
      if (srst) begin
         div_q <= '0;
         tick_q <= 1'b0;
      end else if (div_q == TICK_LAST) begin
         div_q <= '0;
         tick_q <= 1'b1;
      end else begin
         div_q <= div_q + 1'b1;
         tick_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   // Each phase ends on the tick that completes its count
   assign ph_done = tick_q & (
      (state_q == S_QUAL && ph_q == VALID_LAST) ||
      (state_q == S_TRK_ON && ph_q == TRK_ON_LAST) ||
      (state_q == S_TRK_OFF && ph_q == TRK_OFF_LAST) ||
      (state_q == S_CV && ph_q == DGL_LAST));
   assign safe_exp = tick_q & (safe_q == SAFE_LAST);
   // A cycle starts after qualification or on recharge
   assign start = (state_q == S_QUAL && ph_done) ||
                  (state_q == S_DONE && ana_i.batt_below_rech);

   // Next state
   // Overrides rank by severity: supply loss beats input loss,
   // which beats timer expiry; the last write wins
   always_comb begin
      state_d = state_q;
      case (state_q)
         S_SLEEP: begin
            state_d = S_QUAL;
         end
         S_QUAL: begin
            if (ph_done) state_d = entry;
         end
         S_TRK_ON: begin
            if (!ana_i.batt_below_trickle) state_d = entry;
            else if (ph_done) state_d = S_TRK_OFF;
         end
         S_TRK_OFF: begin
            if (!ana_i.batt_below_trickle) state_d = entry;
            else if (ph_done) state_d = S_TRK_ON;
         end
         S_PRE: begin
            if (ana_i.batt_above_pre) state_d = S_CC;
         end
         // Constant voltage once the pack reaches regulation
         S_CC: begin
            if (ana_i.batt_at_reg) state_d = S_CV;
         end
         S_CV: begin
            if (ph_done) state_d = S_DONE;
         end
         // Charger stays off until the pack sags below recharge
         S_DONE: begin
            if (ana_i.batt_below_rech) state_d = entry;
         end
         // Only supply loss, input loss or a stop leaves the fault
         S_FAULT: begin
            state_d = S_FAULT;
         end
         default: begin
            state_d = S_SLEEP;
         end
      endcase
      // Timer expiry ends an unfinished cycle
      if ((charging || state_q == S_TRK_OFF) && safe_exp) begin
         state_d = S_FAULT;
      end
      // Lost or disabled input falls back to qualification
      if (state_q != S_SLEEP && (!vin_valid || off_req)) begin
         state_d = S_QUAL;
      end
      // Supply below lockout forces sleep
      if (!ana_i.vcc_ok) begin
         state_d = S_SLEEP;
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (srst) begin
         state_q <= S_SLEEP;
      end else begin
         state_q <= state_d;
      end
   end

   // Phase timer: clears on every state change, counts ms ticks
   // Qualification restarts while the input is out, so the delay
   // always spans one unbroken stretch of valid input
   always_ff @(posedge clk) begin
      if (srst) begin
         ph_q <= '0;
      end else if (state_d != state_q) begin
         ph_q <= '0;
      end else if (state_q == S_QUAL && (!vin_valid || off_req)) begin
         ph_q <= '0;
      end else if (state_q == S_CV && !(ana_i.ichg_at_term &&
                   tstrap_q == STRAP_GND)) begin
         ph_q <= '0;
      end else if (tick_q) begin
         ph_q <= ph_q + 1'b1;
      end
   end

   // Safety timer: restarts with each cycle, runs while charging
   // Held at its end value so an expiry cannot wrap unseen
   always_ff @(posedge clk) begin
      if (srst) begin
         safe_q <= '0;
      end else if (start || state_q == S_QUAL) begin
         safe_q <= '0;
      end else if ((charging || state_q == S_TRK_OFF) && tick_q &&
                   safe_q != SAFE_LAST) begin
         safe_q <= safe_q + 1'b1;
      end
   end

   // ----------------------------------------
   // Straps and status flags
   // ----------------------------------------
   // Straps are taken once as each cycle begins
   // A strap moved mid-cycle reaches the latched copies only at the next start
   always_ff @(posedge clk) begin
      if (srst) begin
         pstrap_q <= STRAP_GND;
         tstrap_q <= STRAP_GND;
      end else if (start) begin
         pstrap_q <= precharge_threshold_strap;
         tstrap_q <= term_strap;
      end
   end

   // Timeout flag lives until the next cycle; completion and float flags also clear in qualification
   // A set and a clear in one cycle: the set wins
   always_ff @(posedge clk) begin
      if (srst) begin
         tout_q <= 1'b0;
         done_q <= 1'b0;
         float_q <= 1'b0;
      end else begin
         if (state_d == S_FAULT && state_q != S_FAULT) begin
            tout_q <= 1'b1;
         end else if (start) begin
            tout_q <= 1'b0;
         end
         if (state_d == S_DONE && state_q != S_DONE) begin
            done_q <= 1'b1;
         end else if (start || state_q == S_QUAL) begin
            done_q <= 1'b0;
         end
         if (state_q == S_CV && tstrap_q == STRAP_RES &&
             ana_i.ichg_at_100ma) begin
            float_q <= 1'b1;
         end else if (start || state_q == S_QUAL) begin
            float_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Power stage outputs
   // ----------------------------------------
   // All control outputs are registered
   // They lag the state by one cycle; the power stage never
   // sees a decode glitch
   always_ff @(posedge clk) begin
      if (srst) begin
         ctl_o <= '0;
         timeout_fault <= 1'b0;
         charge_done <= 1'b0;
      end else begin
         timeout_fault <= tout_q;
         charge_done <= done_q;
         ctl_o.conv_en <= charging;
         ctl_o.float_reg <= float_q;
         // Back off current on input voltage or input current limit
         ctl_o.cur_reduce <= charging & (ana_i.input_voltage_sense_at_1v2 |
                                         ana_i.iin_at_limit);
         case (state_q)
            S_TRK_ON: ctl_o.cur <= CUR_TRK60;
            S_PRE: ctl_o.cur <= ctrl_q[CTL_TERM_CUR_SEL] ? CUR_PRE100 :
                                CUR_PRE200;
            S_CC, S_CV: ctl_o.cur <= CUR_CHG_SET;
            default: ctl_o.cur <= CUR_OFF;
         endcase
         // Precharge threshold from the strap
         // Live strap, so the comparator settles before a start
         case (precharge_threshold_strap)
            STRAP_FLOAT: ctl_o.pre_thr <= PTH_75;
            STRAP_RES: ctl_o.pre_thr <= PTH_50;
            default: ctl_o.pre_thr <= PTH_70;
         endcase
         // Recharge threshold from strap and select bit
         if (pstrap_q == STRAP_FLOAT) begin
            ctl_o.rech_thr <= RTH_885;
         end else if (ctrl_q[CTL_RECH]) begin
            ctl_o.rech_thr <= RTH_970;
         end else begin
            ctl_o.rech_thr <= RTH_938;
         end
      end
   end

   // ----------------------------------------
   // Wishbone slave
   // ----------------------------------------
   // A request counts once: ack masks the held strobe
   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

   // Ack one cycle after the request, for one cycle
   // Every address is answered, so a stray access
   // cannot hang the master
   always_ff @(posedge clk) begin
      if (srst) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_req;
      end
   end

   // Control register write, low byte lane only
   // Enable resets set, so charging needs no software
   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl_q <= CTRL_RST;
      end else if (wb_req && wb_we_i && wb_sel_i[0] &&
                   wb_adr_i == ADR_CTRL) begin
         ctrl_q <= wb_dat_i[2:0];
      end
   end

   // Read data; unmapped reads return zero
   // Status: state, flags and the straps latched this cycle
   always_ff @(posedge clk) begin
      if (srst) begin
         wb_dat_o <= '0;
      end else if (wb_req) begin
         wb_dat_o <= '0;
         if (wb_adr_i == ADR_CTRL) begin
            wb_dat_o[2:0] <= ctrl_q;
         end else if (wb_adr_i == ADR_STAT) begin
            wb_dat_o[3:0] <= state_q;
            wb_dat_o[ST_TOUT] <= tout_q;
            wb_dat_o[ST_DONE] <= done_q;
            wb_dat_o[ST_FLOAT] <= float_q;
            wb_dat_o[ST_PSTRAP +: 2] <= pstrap_q;
            wb_dat_o[ST_TSTRAP +: 2] <= tstrap_q;
         end
      end
   end
endmodule // bcs_top

`default_nettype wire

// >>> hw/bcs_pkg.sv
// Constants, codes and carrier types of the battery charge sequencer.
// Assumes a 100 MHz clock and analog comparators that deliver clean levels.
package bcs_pkg;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int unsigned CLK_NS = 10; // Clock period
   localparam int unsigned MS_NS = 1000000; // One millisecond
   localparam int unsigned TICK_CYC = MS_NS / CLK_NS; // Cycles per ms tick
   localparam int unsigned T_VALID_MS = 170; // Input qualify delay
   localparam int unsigned T_TRK_ON_MS = 20; // Trickle burst
   localparam int unsigned T_TRK_OFF_S10 = 14; // Trickle pause, tenths of s
   localparam int unsigned T_TRK_OFF_MS = T_TRK_OFF_S10 * 100;
   localparam int unsigned T_TERM_DGL_MS = 50; // Termination deglitch
   localparam int unsigned T_SAFE_H = 20; // Safety timer, hours
   localparam int unsigned T_SAFE_MS = T_SAFE_H * 3600 * 1000;
   localparam int CNT_W = 27; // Width of ms counters
   // ----------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------
   localparam logic [3:0] ADR_CTRL = 4'h0;
   localparam logic [3:0] ADR_STAT = 4'h4;
   localparam int CTL_TERM_CUR_SEL = 0; // Termination current select
   localparam int CTL_RECH = 1; // Recharge threshold select
   localparam int CTL_EN = 2; // Charge enable from controller
   localparam logic [2:0] CTRL_RST = 3'h4;
   localparam int ST_TOUT = 4; // Timeout fault bit
   localparam int ST_DONE = 5; // Cycle complete bit
   localparam int ST_FLOAT = 6; // Float regulation active
   localparam int ST_PSTRAP = 8; // Latched precharge strap, 2 bits
   localparam int ST_TSTRAP = 10; // Latched termination strap, 2 bits
   // ----------------------------------------
   // Codes
   // ----------------------------------------
   // Multi-level strap code from the analog front end
   typedef enum logic [1:0] {
      STRAP_GND = 2'h0, STRAP_FLOAT = 2'h1, STRAP_VCC = 2'h2, STRAP_RES = 2'h3
   } bcs_strap_t;
   // Precharge-to-fast threshold select: 70, 75, 50 percent
   typedef enum logic [1:0] {
      PTH_70 = 2'h0, PTH_75 = 2'h1, PTH_50 = 2'h2
   } bcs_pth_t;
   // Recharge threshold select: 93.8, 97, 88.5 percent
   typedef enum logic [1:0] {
      RTH_938 = 2'h0, RTH_970 = 2'h1, RTH_885 = 2'h2
   } bcs_rth_t;
   // Current request to the power stage
   typedef enum logic [2:0] {
      CUR_OFF = 3'h0, CUR_TRK60 = 3'h1, CUR_PRE200 = 3'h2,
      CUR_PRE100 = 3'h3, CUR_CHG_SET = 3'h4
   } bcs_cur_t;
   // Sequencer states, Gray along the charge path
   typedef enum logic [3:0] {
      S_SLEEP = 4'h0, S_QUAL = 4'h1, S_TRK_ON = 4'h3, S_TRK_OFF = 4'h2,
      S_PRE = 4'h6, S_CC = 4'h7, S_CV = 4'h5, S_DONE = 4'h4, S_FAULT = 4'hc
   } bcs_state_t;
   // Comparator levels from the analog front end
   typedef struct packed {
      logic vcc_ok; // Internal supply above lockout
      logic vin_uvlo_ok; // Input above its lockout
      logic vin_hdrm_ok; // Input above battery plus headroom
      logic batt_below_trickle; // Below trickle exit threshold
      logic batt_above_pre; // Above selected precharge threshold
      logic batt_at_reg; // Battery reached regulation voltage
      logic batt_below_rech; // Below selected recharge threshold
      logic ichg_at_term; // Charge current at termination level
      logic ichg_at_100ma; // Charge current down to about 100 mA
      logic input_voltage_sense_at_1v2; // Input voltage sense at 1.2 V
      logic input_voltage_sense_below_0v2; // Input voltage sense pulled below 0.2 V
      logic iin_at_limit; // Input current at its limit
   } bcs_ana_t;
   // Control levels to the power stage
   typedef struct packed {
      logic conv_en; // Converter enabled
      bcs_cur_t cur; // Current request
      logic cur_reduce; // Back off charge current
      logic float_reg; // Regulate at the lowered float level
      bcs_pth_t pre_thr; // Precharge threshold select
      bcs_rth_t rech_thr; // Recharge threshold select
   } bcs_ctl_t;
endpackage : bcs_pkg

// >>> test/bcs_checker.sv
// Concurrent checks on the charge sequencer ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module bcs_checker
   import bcs_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = 10, // Cycles per ms tick
   parameter int unsigned SAFE_MS = 400 // Safety timer in ticks
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Watched ports
   input wire bcs_ana_t ana_i,
   input wire bcs_strap_t term_strap,
   input wire bcs_ctl_t ctl_o,
   input wire logic charge_done,
   input wire logic timeout_fault
);
   localparam int unsigned T = TICK_CYCLES; // Tick in cycles
   logic good; // Input valid, not disabled
   logic [31:0] good_q; // Cycles of valid input
   logic [31:0] trk_q; // Cycles of running burst
   logic [31:0] term_q; // Cycles at termination level
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   assign good = ana_i.vcc_ok & ana_i.vin_uvlo_ok & ana_i.vin_hdrm_ok &
                 ~ana_i.input_voltage_sense_below_0v2;
   // Run lengths, cleared when their condition drops
   always_ff @(posedge clk) begin
      good_q <= (srst || !good) ? '0 : good_q + 32'h1;
   end
   always_ff @(posedge clk) begin
      trk_q <= (srst || ctl_o.cur != CUR_TRK60) ? '0 : trk_q + 32'h1;
   end
   always_ff @(posedge clk) begin
      term_q <= (srst || !ana_i.ichg_at_term) ? '0 : term_q + 32'h1;
   end
   // ------------------------------
   // Assertions
   // ------------------------------
   a_sleep_off: assert property (
      !ana_i.vcc_ok [*3] |-> !ctl_o.conv_en) else $error("converter on in sleep");
   a_pull_disable: assert property (
      ana_i.input_voltage_sense_below_0v2 [*3] |-> !ctl_o.conv_en)
      else $error("converter on while pulled low");
   a_qual_delay: assert property (
      $rose(ctl_o.conv_en) |-> good_q >= 169 * T) else $error("converter on too early");
   a_burst_len: assert property (
      $fell(ctl_o.cur == CUR_TRK60) && good && ana_i.batt_below_trickle
      |-> trk_q >= 19 * T && trk_q <= 22 * T)
      else $error("trickle burst length wrong");
   a_term_dgl: assert property (
      $rose(charge_done) |-> term_q >= 49 * T && term_strap == STRAP_GND)
      else $error("completion without deglitch");
   a_done_off: assert property (
      $rose(charge_done) |=> ctl_o.cur == CUR_OFF) else $error("current after completion");
   a_fault_off: assert property (
      timeout_fault && $past(timeout_fault) |-> ctl_o.cur == CUR_OFF)
      else $error("current during timeout");
   a_input_reduce: assert property (
      ((ana_i.input_voltage_sense_at_1v2 || ana_i.iin_at_limit) &&
       ctl_o.cur == CUR_CHG_SET) [*3]
      |-> ctl_o.cur_reduce) else $error("no current reduction");
endmodule // bcs_checker
bind bcs_top bcs_checker #(.TICK_CYCLES(TICK_CYCLES), .SAFE_MS(SAFE_MS)) bcs_checker_inst (
   .clk(clk), .srst(srst), .ana_i(ana_i), .term_strap(term_strap), .ctl_o(ctl_o),
   .charge_done(charge_done), .timeout_fault(timeout_fault));
`default_nettype wire

// >>> test/bcs_ana_model.sv
// Behavioural power stage and battery: comparator levels from a battery level.
// Assumes battery level in per mille of regulation voltage, driven by the bench.
`timescale 1ns/1ps
`default_nettype none
module bcs_ana_model
   import bcs_pkg::*;
#(
   parameter logic [9:0] TRK_PM = 10'h12c, // Trickle exit level, per mille
   parameter int TAPER = 20 // Cycles for current to fall at regulation
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Sequencer side
   input wire bcs_ctl_t ctl_i,
   output bcs_ana_t ana_o,
   // Bench side
   input wire logic [9:0] vbat_i,
   input wire bcs_ana_t ext_i
);
   logic [9:0] pre_pm; // Precharge exit level
   logic [9:0] rech_pm; // Recharge level
   logic [7:0] taper_q; // Cycles tapering at regulation
   // Current only tapers while full current is asked at regulation
   always_ff @(posedge clk) begin
      if (srst || !ana_o.batt_at_reg || ctl_i.cur != CUR_CHG_SET) begin
         taper_q <= '0;
      end else if (taper_q < 8'(TAPER)) begin
         taper_q <= taper_q + 8'h1;
      end
   end
   // Comparators follow the selected thresholds
   always_comb begin
      pre_pm = (ctl_i.pre_thr == PTH_75) ? 10'h2ee :
               (ctl_i.pre_thr == PTH_50) ? 10'h1f4 : 10'h2bc;
      rech_pm = (ctl_i.rech_thr == RTH_970) ? 10'h3ca :
                (ctl_i.rech_thr == RTH_885) ? 10'h375 : 10'h3aa;
      ana_o = ext_i;
      ana_o.batt_below_trickle = vbat_i < TRK_PM;
      ana_o.batt_above_pre = vbat_i > pre_pm;
      ana_o.batt_at_reg = vbat_i >= 10'h3e8;
      ana_o.batt_below_rech = vbat_i < rech_pm;
      ana_o.ichg_at_term = taper_q == 8'(TAPER);
      ana_o.ichg_at_100ma = taper_q == 8'(TAPER);
   end
endmodule // bcs_ana_model
`default_nettype wire

// >>> test/tb_battery_charge_sequencer.sv
// Self-checking bench for the charge sequencer.
// Assumes the behavioural battery model and a shortened tick.
`timescale 1ns/1ps
`default_nettype none
module tb_battery_charge_sequencer
   import bcs_pkg::*;
;
   localparam int TK = 10; // Cycles per tick
   localparam int SAFE = 2000; // Safety timer in ticks
   logic clk, srst, wb_cyc, wb_stb, wb_we, wb_ack_o, timeout_fault, charge_done;
   logic [3:0] wb_adr, wb_sel;
   logic [31:0] wb_dat, wb_dat_o;
   bcs_ana_t ext, ana; // Bench flags, model levels
   logic [9:0] vbat; // Battery level, per mille
   bcs_strap_t pstrap, tstrap;
   bcs_ctl_t ctl_o;
   int num_errors, samples_checked;
   bcs_top #(.TICK_CYCLES(TK), .SAFE_MS(SAFE)) bcs_top_inst (
      .clk(clk), .srst(srst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
      .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .ana_i(ana), .precharge_threshold_strap(pstrap),
      .term_strap(tstrap), .ctl_o(ctl_o), .timeout_fault(timeout_fault),
      .charge_done(charge_done));
   bcs_ana_model bcs_ana_model_inst (.clk(clk), .srst(srst), .ctl_i(ctl_o),
      .ana_o(ana), .vbat_i(vbat), .ext_i(ext));
   // ------------------------------
   // Helpers
   // ------------------------------
   task automatic close_out;
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Count in range, else report the count against the low bound
   task automatic rng(input int n, input int lo, input int hi);
      chk(32'((n < lo || n > hi) ? n : lo), 32'(lo));
   endtask
   // One classic cycle; waits for ack under a bound
   task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [31:0] wd,
         output logic [31:0] rd);
      int i;
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_dat <= wd;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (wb_ack_o === 1'b1) break;
      end
      if (i == 20) begin
         chk(32'h0, 32'h1);
         close_out;
      end
      rd = wb_dat_o;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= 1'b0;
      @(posedge clk);
   endtask
   // Wait for cur, done, timeout or float flag to reach v
   task automatic wt(input int k, input logic [2:0] v, input int lim, output int n);
      logic [2:0] s;
      for (n = 0; n < lim; n++) begin
         @(posedge clk);
         s = (k == 0) ? ctl_o.cur : (k == 1) ? {2'h0, charge_done} :
            (k == 2) ? {2'h0, timeout_fault} : {2'h0, ctl_o.float_reg};
         if (s === v) return;
      end
      chk(32'(s), 32'(v));
      close_out;
   endtask
   // Drop input voltage briefly to start a fresh cycle
   task automatic vin_cycle;
      ext.vin_uvlo_ok <= 1'b0;
      repeat (3) @(posedge clk);
      ext.vin_uvlo_ok <= 1'b1;
   endtask
   // ------------------------------
   // Scenarios
   // ------------------------------
   task automatic t_regs;
      logic [31:0] d;
      ext.vin_uvlo_ok <= 1'b1;
      ext.vin_hdrm_ok <= 1'b1;
      repeat (300) @(posedge clk);
      chk(ctl_o.conv_en, 1'b0);
      wb_xfer(1'b0, ADR_CTRL, 32'h0, d);
      chk(d, 32'h4);
      wb_xfer(1'b0, 4'h8, 32'h0, d);
      chk(d, 32'h0);
      wb_xfer(1'b1, ADR_STAT, 32'hff, d);
      wb_xfer(1'b0, ADR_STAT, 32'h0, d);
      chk(d[3:0], S_SLEEP);
   endtask
   task automatic t_trickle;
      int n;
      logic [31:0] d;
      vbat <= 10'hc8;
      ext.vcc_ok <= 1'b1;
      wt(0, CUR_TRK60, 3000, n);
      rng(n, 169 * TK, 172 * TK);
      wt(0, CUR_OFF, 400, n);
      rng(n, 19 * TK, 22 * TK);
      wt(0, CUR_TRK60, 16000, n);
      rng(n, 1399 * TK, 1423 * TK);
      vbat <= 10'h258;
      wt(0, CUR_PRE200, 100, n);
      wb_xfer(1'b1, ADR_CTRL, 32'h1, d);
      wb_xfer(1'b1, ADR_CTRL, 32'h5, d);
      wt(0, CUR_PRE100, 3000, n);
   endtask
   task automatic t_cc;
      int n;
      vbat <= 10'h320;
      wt(0, CUR_CHG_SET, 100, n);
      for (int i = 0; i < 2; i++) begin
         ext.input_voltage_sense_at_1v2 <= (i == 0);
         ext.iin_at_limit <= (i == 1);
         repeat (4) @(posedge clk);
         chk(ctl_o.cur_reduce, 1'b1);
      end
      ext.iin_at_limit <= 1'b0;
      repeat (4) @(posedge clk);
      chk(ctl_o.cur_reduce, 1'b0);
      ext.input_voltage_sense_below_0v2 <= 1'b1;
      repeat (4) @(posedge clk);
      chk(ctl_o.conv_en, 1'b0);
      ext.input_voltage_sense_below_0v2 <= 1'b0;
      wt(0, CUR_CHG_SET, 3000, n);
   endtask
   task automatic t_done;
      int n;
      vbat <= 10'h3e8;
      wt(1, 3'h1, 1000, n);
      rng(n, 49 * TK, 56 * TK + 30);
      repeat (2) @(posedge clk);
      chk(ctl_o.cur, CUR_OFF);
      vbat <= 10'h3c0;
      repeat (100) @(posedge clk);
      chk(ctl_o.cur, CUR_OFF);
      tstrap <= STRAP_VCC;
      vbat <= 10'h3a2;
      wt(0, CUR_CHG_SET, 100, n);
      vbat <= 10'h3e8;
      wt(2, 3'h1, 25000, n);
      rng(n, (SAFE - 2) * TK, (SAFE + 2) * TK);
      repeat (2) @(posedge clk);
      chk(ctl_o.cur, CUR_OFF);
      chk(charge_done, 1'b0);
   endtask
   task automatic t_straps;
      int n;
      logic [31:0] d;
      pstrap <= STRAP_FLOAT;
      tstrap <= STRAP_RES;
      vbat <= 10'h258;
      wb_xfer(1'b1, ADR_CTRL, 32'h6, d);
      vin_cycle;
      wt(0, CUR_PRE200, 3000, n);
      chk(ctl_o.pre_thr, PTH_75);
      chk(ctl_o.rech_thr, RTH_885);
      vbat <= 10'h3e8;
      wt(3, 3'h1, 1000, n);
      wb_xfer(1'b0, ADR_STAT, 32'h0, d);
      chk(d[11:4], 8'hd4);
      repeat (600) @(posedge clk);
      chk(charge_done, 1'b0);
      pstrap <= STRAP_VCC;
      vbat <= 10'h258;
      vin_cycle;
      wt(0, CUR_CHG_SET, 3000, n);
      chk(ctl_o.rech_thr, RTH_970);
      pstrap <= STRAP_RES;
      repeat (3) @(posedge clk);
      chk(ctl_o.pre_thr, PTH_50);
   endtask
   // Free-running clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Reset, then scenarios in order
   initial begin
      num_errors = 0;
      samples_checked = 0;
      srst = 1'b1;
      wb_cyc = 1'b0;
      wb_stb = 1'b0;
      wb_we = 1'b0;
      wb_adr = 4'h0;
      wb_sel = 4'hf;
      wb_dat = 32'h0;
      ext = '0;
      vbat = 10'h0;
      pstrap = STRAP_GND;
      tstrap = STRAP_GND;
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      t_regs;
      t_trickle;
      t_cc;
      t_done;
      t_straps;
      close_out;
   end
endmodule // tb_battery_charge_sequencer
`default_nettype wire
